// [bench/hdpc_far_model.sv]
`timescale 1ns/1ps
`default_nettype none
module hdpc_far_model (
    // Clock
    input wire logic sys_clk,
    // Detector stimulus
    input wire logic [1:0] acc_type,
    input wire logic plugged,
    input wire logic pressed,
    output var hdpc_pkg::hdpc_sense_t sense_raw,
    // Pin loads
    input wire logic ext_en,
    input wire logic ext_lvl,
    input wire logic pin_a_out,
    input wire logic pin_a_oe,
    input wire logic pin_b_out,
    input wire logic pin_b_oe,
    output var logic pin_a_in,
    output var logic pin_b_in
);
    logic flt = 1'b0;

    // An undriven pin toggles so a stale level can never pass for a real one
    always_ff @(posedge sys_clk) begin
        flt <= ~flt;
    end

    always_comb begin
        sense_raw = {acc_type, plugged, pressed};
        pin_a_in = pin_a_oe ? pin_a_out : (ext_en ? ext_lvl : flt);
        pin_b_in = pin_b_oe ? pin_b_out : (ext_en ? ext_lvl : flt);
    end
endmodule
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int MS = 10;
    localparam logic [6:0] DET = hdpc_pkg::ADDR_DET_CTRL;
    localparam logic [6:0] PIN = hdpc_pkg::ADDR_PIN_CTRL;
    logic sys_clk, reset_n, reg_wr_en, reg_rd_en;
    logic [6:0] reg_addr;
    logic [15:0] reg_wr_data, reg_rd_data;
    hdpc_pkg::hdpc_sense_t sense_raw;
    logic pll_en, playback_faster, playback_clk256, record_clk256, adc_frame_select;
    logic pin_a_in, pin_a_out, pin_a_oe, pin_b_in, pin_b_out, pin_b_oe;
    logic [1:0] acc_type;
    logic plugged, pressed, ext_en, ext_lvl;
    int err_count;
    int comparisons;

    hdpc_pin_ctrl #(.CYCLES_PER_MS(MS)) hdpc_pin_ctrl_i (
        .sys_clk, .reset_n, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data,
        .sense_raw, .pll_en, .playback_faster, .playback_clk256, .record_clk256,
        .adc_frame_select, .pin_a_in, .pin_a_out, .pin_a_oe, .pin_b_in, .pin_b_out, .pin_b_oe
    );

    hdpc_far_model hdpc_far_model_i (
        .sys_clk, .acc_type, .plugged, .pressed, .sense_raw, .ext_en, .ext_lvl,
        .pin_a_out, .pin_a_oe, .pin_b_out, .pin_b_oe, .pin_a_in, .pin_b_in
    );

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Every task starts and ends 1 ns after a rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wr_data = d;
        reg_wr_en = 1'b1;
        cyc(1);
        reg_wr_en = 1'b0;
        // An idle edge keeps back-to-back calls from retoggling the strobe
        cyc(1);
    endtask

    task automatic rd(input logic [6:0] a, input logic [15:0] msk, input logic [15:0] exp,
                      input string what);
        reg_addr = a;
        reg_rd_en = 1'b1;
        cyc(1);
        reg_rd_en = 1'b0;
        chk(what, exp & msk, reg_rd_data & msk);
        cyc(1);
    endtask

    // Order: pin A enable, pin A level, pin B enable, pin B level
    task automatic pins(input logic [3:0] exp, input string what);
        chk(what, {12'h0, exp}, {12'h0, pin_a_oe, pin_a_out, pin_b_oe, pin_b_out});
    endtask

    task automatic t_reset;
        rd(DET, 16'hffff, 16'h0200, "det reset");
        rd(PIN, 16'hffff, 16'h0000, "pin reset");
        rd(7'h24, 16'hffff, 16'h0000, "unmapped read");
        pins(4'h0, "pins after reset");
    endtask

    task automatic t_access;
        wr(DET, 16'h7edf);
        rd(DET, 16'hffff, 16'h06df, "det image");
        ext_en = 1'b0;
        wr(PIN, 16'hff00);
        cyc(5);
        rd(PIN, 16'hffff, 16'hff00, "pin image");
        wr(PIN, 16'h0000);
        wr(DET, 16'h0200);
    endtask

    task automatic t_gpo;
        for (int i = 0; i < 4; i++) begin
            wr(PIN, {1'b1, i[1], 2'b00, 1'b1, i[0], 10'h000});
            cyc(1);
            pins({1'b1, i[0], 1'b1, i[1]}, "gpo drive");
        end
        wr(PIN, 16'h0000);
        cyc(1);
        pins(4'h0, "gpo released");
    endtask

    task automatic t_gpi;
        ext_en = 1'b1;
        ext_lvl = 1'b1;
        wr(PIN, 16'h2200);
        cyc(5);
        for (int l = 0; l < 2; l++) begin
            ext_lvl = l[0];
            rd(PIN, 16'h1100, l[0] ? 16'h0000 : 16'h1100, "input not yet seen");
            cyc(4);
            rd(PIN, 16'h1100, l[0] ? 16'h1100 : 16'h0000, "input level");
        end
        pins(4'h0, "gpi not driven");
        wr(PIN, 16'h0000);
        ext_en = 1'b0;
    endtask

    task automatic t_detect;
        int tk;
        for (int s = 0; s < 4; s++) begin
            tk = (2 << s) * MS;
            plugged = 1'b0;
            pressed = 1'b0;
            wr(DET, 16'h0000);
            cyc(2);
            acc_type = s[1:0];
            plugged = 1'b1;
            pressed = 1'b1;
            wr(DET, {1'b1, 4'h0, s[1:0], 1'b0, s[1:0], 2'b01, s == 3, 1'b0, s != 3, 1'b0});
            cyc(2);
            rd(DET, 16'h0800, {4'h0, s == 0, 11'h0}, "button early");
            cyc(6 * tk - 3);
            rd(DET, 16'h1800, 16'h0800, "headset early");
            cyc(4 * tk);
            rd(DET, 16'hf800, {1'b1, s[1:0], 2'b11, 11'h0}, "detected");
            pins(4'hf, "irq pins");
        end
        wr(DET, 16'h0212);
        cyc(1);
        rd(DET, 16'h7800, 16'h0000, "detect off");
        plugged = 1'b0;
        pressed = 1'b0;
    endtask

    task automatic t_clock;
        wr(DET, 16'h0204);
        pll_en = 1'b1;
        playback_faster = 1'b1;
        playback_clk256 = 1'b1;
        record_clk256 = 1'b0;
        cyc(3);
        pins(4'b0011, "clock from playback");
        playback_faster = 1'b0;
        cyc(2);
        pins(4'b0010, "clock from record");
        pll_en = 1'b0;
        cyc(2);
        pins(4'b0000, "clock needs pll");
        pll_en = 1'b1;
        wr(PIN, 16'h2000);
        cyc(1);
        pins(4'b0000, "clock blocked by input");
        wr(PIN, 16'h0000);
    endtask

    task automatic t_frame;
        // Record and playback rates differ here
        wr(DET, 16'h0203);
        adc_frame_select = 1'b1;
        cyc(2);
        pins(4'b1100, "frame high");
        adc_frame_select = 1'b0;
        cyc(2);
        pins(4'b1000, "frame low");
        adc_frame_select = 1'b1;
        wr(PIN, 16'h0800);
        cyc(1);
        pins(4'b1000, "output overrides frame");
        wr(DET, 16'h0201);
        wr(PIN, 16'h0000);
        cyc(1);
        pins(4'b0000, "select hiz");
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    initial begin
        #200000;
        err_count++;
        wrap_up();
    end

    initial begin
        err_count = 0;
        comparisons = 0;
        reset_n = 1'b0;
        {reg_wr_en, reg_rd_en, reg_addr, reg_wr_data} = '0;
        {pll_en, playback_faster, playback_clk256, record_clk256, adc_frame_select} = '0;
        {acc_type, plugged, pressed, ext_en, ext_lvl} = '0;
        repeat (3) @(posedge sys_clk);
        #1;
        reset_n = 1'b1;
        t_reset();
        t_access();
        t_gpo();
        t_gpi();
        t_detect();
        t_clock();
        t_frame();
        wrap_up();
    end
endmodule
`default_nettype wire

// [core/hdpc_debounce.sv]
`timescale 1ns/1ps
`default_nettype none
module hdpc_debounce #(
    parameter int WIDTH = 1,
    parameter int TICKS = hdpc_pkg::DEB_TICKS
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Filter control
    input wire logic tick,
    input wire logic bypass,
    input wire logic clear,
    // Data
    input wire logic [WIDTH-1:0] raw,
    output logic [WIDTH-1:0] stable
);
    localparam int CW = $clog2(TICKS);

    typedef struct packed {
        logic [WIDTH-1:0] cand;
        logic [CW-1:0] cnt;
        logic [WIDTH-1:0] out;
    } hdpc_deb_st_t;

    hdpc_deb_st_t st_ff;
    hdpc_deb_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (clear) begin
            nxt_st = '0;
        end else if (bypass) begin
            nxt_st.cand = raw;
            nxt_st.cnt = '0;
            nxt_st.out = raw;
        end else if (raw != st_ff.cand) begin
            // Any movement restarts the stability window
            nxt_st.cand = raw;
            nxt_st.cnt = '0;
        end else if (tick) begin
            if (st_ff.cnt == CW'(TICKS - 1)) begin
                nxt_st.out = st_ff.cand;
            end else begin
                nxt_st.cnt = st_ff.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign stable = st_ff.out;
endmodule
`default_nettype wire

// [core/hdpc_pin_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
// Function
// - Headset detection runs only while the detection-enable bit is one.
// - Accessory type field: none, stereo, cellular, or both.
// - Accessory type only meaningful while detection is enabled.
// - Read-only flag shows a detected headset.
// - Read-only flag shows a detected button press.
// - Headset debounce 16 to 128 ms in 2 to 16 ms ticks, reset 01.
// - Button debounce none, 8, 16 or 32 ms in 1 to 4 ms ticks.
// - Pin B carries detection interrupt when enabled and not a GPIO.
// - Pin A carries detection interrupt when enabled and not a GPIO.
// - Pin B clock output at 256 times the faster sample rate.
// - Clock output needs PLL on, no GPIO role, no interrupt role.
// - Pin A select: 0X high impedance, 10 button interrupt, 11 ADC frame.
// - Pin A select applies only while pin A is neither a GPIO nor the detection interrupt.
// - ADC frame select only used when record and playback rates differ.
// - Pin B output-enable bit makes pin B a general-purpose output.
// - Pin B output drives its level bit.
// - Pin B input-enable makes it an input; flag shows its level.
// - Pin A output-enable makes it an output driving its level bit.
// - Pin A input-enable makes it an input; level flag valid then.
module hdpc_pin_ctrl #(
    parameter int CYCLES_PER_MS = hdpc_pkg::CYCLES_PER_MS
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Register port
    input wire logic [6:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [15:0] reg_wr_data,
    input wire logic reg_rd_en,
    output logic [15:0] reg_rd_data,
    // Analog detector
    input wire hdpc_pkg::hdpc_sense_t sense_raw,
    // Clocking and framing sources
    input wire logic pll_en,
    input wire logic playback_faster,
    input wire logic playback_clk256,
    input wire logic record_clk256,
    input wire logic adc_frame_select,
    // Pin A
    input wire logic pin_a_in,
    output logic pin_a_out,
    output logic pin_a_oe,
    // Pin B
    input wire logic pin_b_in,
    output logic pin_b_out,
    output logic pin_b_oe
);
    localparam int MS_W = $clog2(CYCLES_PER_MS);
    localparam int GAP_W = MS_W + 5; // Room for the longest headset tick period

    typedef struct packed {
        hdpc_pkg::hdpc_det_ctrl_t det;
        hdpc_pkg::hdpc_pin_ctrl_t pin;
        logic [MS_W-1:0] ms_cnt;
        logic [3:0] hs_div;
        logic [1:0] btn_div;
        logic [GAP_W-1:0] hs_gap;
        logic hs_full;
        logic a_sync1;
        logic a_sync2;
        logic b_sync1;
        logic b_sync2;
        logic a_in_level;
        logic b_in_level;
        hdpc_pkg::hdpc_role_t role_a;
        hdpc_pkg::hdpc_role_t role_b;
        logic a_out;
        logic a_oe;
        logic b_out;
        logic b_oe;
        logic [15:0] rd_data;
    } hdpc_st_t;

    hdpc_st_t st_ff;
    hdpc_st_t nxt_st;

    logic ms_tick;
    logic hs_tick;
    logic btn_tick;
    logic [3:0] hs_limit;
    logic [1:0] btn_limit;
    logic [2:0] hs_stable;
    logic btn_stable;
    logic det_clear;
    logic btn_bypass;
    logic clk_sel;
    logic [15:0] det_rd;
    logic [15:0] pin_rd;
    hdpc_pkg::hdpc_role_t role_a;
    hdpc_pkg::hdpc_role_t role_b;

    // Time base ticks; all counters idle while detection is off
    always_comb begin
        det_clear = !st_ff.det.det_en;
        ms_tick = (st_ff.ms_cnt == MS_W'(CYCLES_PER_MS - 1));
        hs_limit = (4'(hdpc_pkg::HS_BASE_MS) << st_ff.det.hs_deb) - 4'h1;
        btn_bypass = (st_ff.det.btn_deb == hdpc_pkg::BTN_DEB_OFF);
        btn_limit = (2'(hdpc_pkg::BTN_BASE_MS) << (st_ff.det.btn_deb - 2'h1)) - 2'h1;
        hs_tick = ms_tick && (st_ff.hs_div == hs_limit);
        btn_tick = ms_tick && (st_ff.btn_div == btn_limit);
    end

    hdpc_debounce #(
        .WIDTH(3),
        .TICKS(hdpc_pkg::DEB_TICKS)
    ) u_hs_deb (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .tick(hs_tick),
        .bypass(1'b0),
        .clear(det_clear),
        .raw({sense_raw.cellular, sense_raw.stereo, sense_raw.present}),
        .stable(hs_stable)
    );

    hdpc_debounce #(
        .WIDTH(1),
        .TICKS(hdpc_pkg::DEB_TICKS)
    ) u_btn_deb (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .tick(btn_tick),
        .bypass(btn_bypass),
        .clear(det_clear),
        .raw(sense_raw.button),
        .stable(btn_stable)
    );

    // GPIO roles take priority over every special function
    always_comb begin
        if (st_ff.pin.a_out_en) begin
            role_a = hdpc_pkg::ROLE_GPO;
        end else if (st_ff.pin.a_in_en) begin
            role_a = hdpc_pkg::ROLE_GPI;
        end else if (st_ff.det.a_irq_en) begin
            role_a = hdpc_pkg::ROLE_DET_IRQ;
        end else if (st_ff.det.a_func == hdpc_pkg::A_FUNC_BTN_IRQ) begin
            role_a = hdpc_pkg::ROLE_BTN_IRQ;
        end else if (st_ff.det.a_func == hdpc_pkg::A_FUNC_ADC_WS) begin
            role_a = hdpc_pkg::ROLE_ADC_WS;
        end else begin
            role_a = hdpc_pkg::ROLE_HIZ;
        end
        if (st_ff.pin.b_out_en) begin
            role_b = hdpc_pkg::ROLE_GPO;
        end else if (st_ff.pin.b_in_en) begin
            role_b = hdpc_pkg::ROLE_GPI;
        end else if (st_ff.det.b_irq_en) begin
            role_b = hdpc_pkg::ROLE_DET_IRQ;
        end else if (st_ff.det.b_clk_en && pll_en) begin
            role_b = hdpc_pkg::ROLE_CLK;
        end else begin
            role_b = hdpc_pkg::ROLE_HIZ;
        end
    end

    // Readback images; reserved bits stay zero
    always_comb begin
        det_rd = '0;
        det_rd[hdpc_pkg::DET_EN_BIT] = st_ff.det.det_en;
        det_rd[hdpc_pkg::ACC_TYPE_LSB +: 2] = hs_stable[2:1];
        det_rd[hdpc_pkg::HS_FLAG_BIT] = hs_stable[0];
        det_rd[hdpc_pkg::BTN_FLAG_BIT] = btn_stable;
        det_rd[hdpc_pkg::HS_DEB_LSB +: 2] = st_ff.det.hs_deb;
        det_rd[hdpc_pkg::BTN_DEB_LSB +: 2] = st_ff.det.btn_deb;
        det_rd[hdpc_pkg::B_IRQ_BIT] = st_ff.det.b_irq_en;
        det_rd[hdpc_pkg::A_IRQ_BIT] = st_ff.det.a_irq_en;
        det_rd[hdpc_pkg::B_CLK_BIT] = st_ff.det.b_clk_en;
        det_rd[hdpc_pkg::A_FUNC_LSB +: 2] = st_ff.det.a_func;
        pin_rd = '0;
        pin_rd[hdpc_pkg::B_OUT_EN_BIT] = st_ff.pin.b_out_en;
        pin_rd[hdpc_pkg::B_OUT_LVL_BIT] = st_ff.pin.b_out_level;
        pin_rd[hdpc_pkg::B_IN_EN_BIT] = st_ff.pin.b_in_en;
        pin_rd[hdpc_pkg::B_IN_LVL_BIT] = st_ff.b_in_level;
        pin_rd[hdpc_pkg::A_OUT_EN_BIT] = st_ff.pin.a_out_en;
        pin_rd[hdpc_pkg::A_OUT_LVL_BIT] = st_ff.pin.a_out_level;
        pin_rd[hdpc_pkg::A_IN_EN_BIT] = st_ff.pin.a_in_en;
        pin_rd[hdpc_pkg::A_IN_LVL_BIT] = st_ff.a_in_level;
    end

    always_comb begin
        clk_sel = playback_faster ? playback_clk256 : record_clk256;
        nxt_st = st_ff;
        // Time base
        if (det_clear || ms_tick) begin
            nxt_st.ms_cnt = '0;
        end else begin
            nxt_st.ms_cnt = st_ff.ms_cnt + 1'b1;
        end
        if (det_clear || hs_tick) begin
            nxt_st.hs_div = '0;
        end else if (ms_tick) begin
            nxt_st.hs_div = st_ff.hs_div + 4'h1;
        end
        if (det_clear || btn_tick || btn_bypass) begin
            nxt_st.btn_div = '0;
        end else if (ms_tick) begin
            nxt_st.btn_div = st_ff.btn_div + 2'h1;
        end
        // Tick spacing monitor; a write while running spoils one period
        nxt_st.hs_gap = (det_clear || hs_tick) ? '0 : st_ff.hs_gap + 1'b1;
        if (det_clear) begin
            nxt_st.hs_full = 1'b1;
        end else if (reg_wr_en && reg_addr == hdpc_pkg::ADDR_DET_CTRL) begin
            nxt_st.hs_full = 1'b0;
        end else if (hs_tick) begin
            nxt_st.hs_full = 1'b1;
        end
        // Synchronisers: stage one feeds stage two only
        nxt_st.a_sync1 = pin_a_in;
        nxt_st.a_sync2 = st_ff.a_sync1;
        nxt_st.b_sync1 = pin_b_in;
        nxt_st.b_sync2 = st_ff.b_sync1;
        // Level flags freeze when input mode is off
        if (st_ff.pin.a_in_en) begin
            nxt_st.a_in_level = st_ff.a_sync2;
        end
        if (st_ff.pin.b_in_en) begin
            nxt_st.b_in_level = st_ff.b_sync2;
        end
        // Register writes; reserved bits are dropped
        if (reg_wr_en && reg_addr == hdpc_pkg::ADDR_DET_CTRL) begin
            nxt_st.det.det_en = reg_wr_data[hdpc_pkg::DET_EN_BIT];
            nxt_st.det.hs_deb = reg_wr_data[hdpc_pkg::HS_DEB_LSB +: 2];
            nxt_st.det.btn_deb = reg_wr_data[hdpc_pkg::BTN_DEB_LSB +: 2];
            nxt_st.det.b_irq_en = reg_wr_data[hdpc_pkg::B_IRQ_BIT];
            nxt_st.det.a_irq_en = reg_wr_data[hdpc_pkg::A_IRQ_BIT];
            nxt_st.det.b_clk_en = reg_wr_data[hdpc_pkg::B_CLK_BIT];
            nxt_st.det.a_func = reg_wr_data[hdpc_pkg::A_FUNC_LSB +: 2];
        end
        if (reg_wr_en && reg_addr == hdpc_pkg::ADDR_PIN_CTRL) begin
            nxt_st.pin.b_out_en = reg_wr_data[hdpc_pkg::B_OUT_EN_BIT];
            nxt_st.pin.b_out_level = reg_wr_data[hdpc_pkg::B_OUT_LVL_BIT];
            nxt_st.pin.b_in_en = reg_wr_data[hdpc_pkg::B_IN_EN_BIT];
            nxt_st.pin.a_out_en = reg_wr_data[hdpc_pkg::A_OUT_EN_BIT];
            nxt_st.pin.a_out_level = reg_wr_data[hdpc_pkg::A_OUT_LVL_BIT];
            nxt_st.pin.a_in_en = reg_wr_data[hdpc_pkg::A_IN_EN_BIT];
        end
        // Reads return zero outside the two registers
        if (reg_rd_en) begin
            if (reg_addr == hdpc_pkg::ADDR_DET_CTRL) begin
                nxt_st.rd_data = det_rd;
            end else if (reg_addr == hdpc_pkg::ADDR_PIN_CTRL) begin
                nxt_st.rd_data = pin_rd;
            end else begin
                nxt_st.rd_data = '0;
            end
        end
        // Pin drivers
        nxt_st.role_a = role_a;
        nxt_st.role_b = role_b;
        nxt_st.a_out = 1'b0;
        nxt_st.a_oe = 1'b1;
        case (role_a)
            hdpc_pkg::ROLE_GPO: nxt_st.a_out = st_ff.pin.a_out_level;
            hdpc_pkg::ROLE_DET_IRQ: nxt_st.a_out = hs_stable[0];
            hdpc_pkg::ROLE_BTN_IRQ: nxt_st.a_out = btn_stable;
            hdpc_pkg::ROLE_ADC_WS: nxt_st.a_out = adc_frame_select;
            default: nxt_st.a_oe = 1'b0;
        endcase
        nxt_st.b_out = 1'b0;
        nxt_st.b_oe = 1'b1;
        case (role_b)
            hdpc_pkg::ROLE_GPO: nxt_st.b_out = st_ff.pin.b_out_level;
            hdpc_pkg::ROLE_DET_IRQ: nxt_st.b_out = hs_stable[0];
            hdpc_pkg::ROLE_CLK: nxt_st.b_out = clk_sel;
            default: nxt_st.b_oe = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
            st_ff.det.hs_deb <= hdpc_pkg::HS_DEB_RST;
            st_ff.det.btn_deb <= hdpc_pkg::BTN_DEB_RST;
            st_ff.role_a <= hdpc_pkg::ROLE_HIZ;
            st_ff.role_b <= hdpc_pkg::ROLE_HIZ;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rd_data = st_ff.rd_data;
    assign pin_a_out = st_ff.a_out;
    assign pin_a_oe = st_ff.a_oe;
    assign pin_b_out = st_ff.b_out;
    assign pin_b_oe = st_ff.b_oe;

    property p_det_off_flags;
        @(posedge sys_clk) disable iff (!reset_n)
        !st_ff.det.det_en |=> (hs_stable == 3'h0) && !btn_stable;
    endproperty
    a_det_off_flags: assert property (p_det_off_flags) else $error("flags set while off");

    property p_type_needs_en;
        @(posedge sys_clk) disable iff (!reset_n)
        (hs_stable[2:1] != 2'h0) |-> $past(st_ff.det.det_en);
    endproperty
    a_type_needs_en: assert property (p_type_needs_en) else $error("type while off");

    property p_present_rise;
        @(posedge sys_clk) disable iff (!reset_n)
        $rose(hs_stable[0]) |-> $past(sense_raw.present) && $past(hs_tick);
    endproperty
    a_present_rise: assert property (p_present_rise) else $error("present rose untimed");

    property p_hs_tick_period;
        @(posedge sys_clk) disable iff (!reset_n)
        hs_tick && st_ff.hs_full |-> st_ff.hs_gap ==
            GAP_W'((hdpc_pkg::HS_BASE_MS << st_ff.det.hs_deb) * CYCLES_PER_MS - 1);
    endproperty
    a_hs_tick_period: assert property (p_hs_tick_period) else $error("bad headset tick");

    property p_btn_bypass;
        @(posedge sys_clk) disable iff (!reset_n)
        (st_ff.det.det_en && btn_bypass && sense_raw.button) |=> btn_stable;
    endproperty
    a_btn_bypass: assert property (p_btn_bypass) else $error("button not passed");

    property p_b_gpo;
        @(posedge sys_clk) disable iff (!reset_n)
        st_ff.pin.b_out_en |=> pin_b_oe && (pin_b_out == $past(st_ff.pin.b_out_level));
    endproperty
    a_b_gpo: assert property (p_b_gpo) else $error("pin b output wrong");

    property p_a_gpo;
        @(posedge sys_clk) disable iff (!reset_n)
        st_ff.pin.a_out_en |=> pin_a_oe && (pin_a_out == $past(st_ff.pin.a_out_level));
    endproperty
    a_a_gpo: assert property (p_a_gpo) else $error("pin a output wrong");

    property p_b_irq;
        @(posedge sys_clk) disable iff (!reset_n)
        (!st_ff.pin.b_out_en && !st_ff.pin.b_in_en && st_ff.det.b_irq_en)
            |=> pin_b_oe && (pin_b_out == $past(hs_stable[0]));
    endproperty
    a_b_irq: assert property (p_b_irq) else $error("pin b irq wrong");

    property p_a_hiz;
        @(posedge sys_clk) disable iff (!reset_n)
        (!st_ff.pin.a_out_en && (st_ff.pin.a_in_en || (!st_ff.det.a_irq_en
            && !st_ff.det.a_func[1]))) |=> !pin_a_oe;
    endproperty
    a_a_hiz: assert property (p_a_hiz) else $error("pin a driven");

    property p_clk_needs_pll;
        @(posedge sys_clk) disable iff (!reset_n)
        (!pll_en && !st_ff.pin.b_out_en && !st_ff.det.b_irq_en) |=> !pin_b_oe;
    endproperty
    a_clk_needs_pll: assert property (p_clk_needs_pll) else $error("clock without pll");

    property p_sync_depth;
        @(posedge sys_clk) disable iff (!reset_n)
        st_ff.pin.a_in_en ##1 st_ff.pin.a_in_en |-> st_ff.a_in_level == $past(pin_a_in, 3);
    endproperty
    a_sync_depth: assert property (p_sync_depth) else $error("sync depth wrong");

    c_headset: cover property (@(posedge sys_clk) disable iff (!reset_n) $rose(hs_stable[0]));
    c_button: cover property (@(posedge sys_clk) disable iff (!reset_n) $rose(btn_stable));
    c_clock_out: cover property (@(posedge sys_clk) disable iff (!reset_n)
        st_ff.role_b == hdpc_pkg::ROLE_CLK);
endmodule
`default_nettype wire

// [core/hdpc_pkg.sv]
package hdpc_pkg;
    // Register indices on the serial control port
    localparam logic [6:0] ADDR_DET_CTRL = 7'h22;
    localparam logic [6:0] ADDR_PIN_CTRL = 7'h23;

    // Detection control field positions
    localparam int DET_EN_BIT = 15;
    localparam int ACC_TYPE_LSB = 13;
    localparam int HS_FLAG_BIT = 12;
    localparam int BTN_FLAG_BIT = 11;
    localparam int HS_DEB_LSB = 9;
    localparam int BTN_DEB_LSB = 6;
    localparam int B_IRQ_BIT = 4;
    localparam int A_IRQ_BIT = 3;
    localparam int B_CLK_BIT = 2;
    localparam int A_FUNC_LSB = 0;

    // Pin control field positions
    localparam int B_OUT_EN_BIT = 15;
    localparam int B_OUT_LVL_BIT = 14;
    localparam int B_IN_EN_BIT = 13;
    localparam int B_IN_LVL_BIT = 12;
    localparam int A_OUT_EN_BIT = 11;
    localparam int A_OUT_LVL_BIT = 10;
    localparam int A_IN_EN_BIT = 9;
    localparam int A_IN_LVL_BIT = 8;

    // Reset values of the debounce selects, and the button debounce bypass code
    localparam logic [1:0] HS_DEB_RST = 2'h1;
    localparam logic [1:0] BTN_DEB_RST = 2'h0;
    localparam logic [1:0] BTN_DEB_OFF = 2'h0;

    // Pin A function select codes
    localparam logic [1:0] A_FUNC_BTN_IRQ = 2'h2;
    localparam logic [1:0] A_FUNC_ADC_WS = 2'h3;

    // Timing: 200 MHz clock, millisecond time base
    localparam int CLK_FREQ_KHZ = 200000;
    localparam int TICK_MS = 1;
    localparam int CYCLES_PER_MS = TICK_MS * CLK_FREQ_KHZ;
    localparam int HS_BASE_MS = 2;
    localparam int BTN_BASE_MS = 1;
    localparam int DEB_TICKS = 8;

    typedef enum logic [6:0] {
        ROLE_HIZ = 7'h01,
        ROLE_GPO = 7'h02,
        ROLE_GPI = 7'h04,
        ROLE_DET_IRQ = 7'h08,
        ROLE_BTN_IRQ = 7'h10,
        ROLE_CLK = 7'h20,
        ROLE_ADC_WS = 7'h40
    } hdpc_role_t;

    typedef struct packed {
        logic det_en;
        logic [1:0] hs_deb;
        logic [1:0] btn_deb;
        logic b_irq_en;
        logic a_irq_en;
        logic b_clk_en;
        logic [1:0] a_func;
    } hdpc_det_ctrl_t;

    typedef struct packed {
        logic b_out_en;
        logic b_out_level;
        logic b_in_en;
        logic a_out_en;
        logic a_out_level;
        logic a_in_en;
    } hdpc_pin_ctrl_t;

    typedef struct packed {
        logic cellular;
        logic stereo;
        logic present;
        logic button;
    } hdpc_sense_t;
endpackage
